/* File: src/xhci_capability_param_regs.sv */
`timescale 1ns/1ps
module xhci_capability_param_regs #(
  parameter logic [31:0] BAR_SIZE    = xhci_cap_pkg::BAR_SIZE_DEFAULT,
  parameter logic [15:0] HCI_VERSION = xhci_cap_pkg::HCI_VERSION_RESET
) (
  input  wire logic                  clk_sys,        // system clock
  input  wire logic                  arst_n,         // async reset
  input  wire logic [31:0]           barBase,        // first base address
  input  wire logic                  powerCtlAbsent, // control reg bit
  input  wire logic                  reqValid,       // request strobe
  input  wire logic                  reqWrite,       // 1 write, 0 read
  input  wire logic [31:0]           reqAddr,        // absolute address
  input  wire logic [3:0]            reqByteEn,      // byte lanes
  output logic                       reqReady,       // can take request
  output logic                       rspValid,       // answer pulse
  output logic [31:0]                rspData,        // read data
  output logic                       rspHit,         // served here
  output xhci_cap_pkg::region_t      rspRegion,      // decoded region
  output logic [15:0]                rspRelOffset,   // region offset
  output logic [31:0]                operationalBase, // oper base addr
  output logic                       writeIgnored    // ro write pulse
);

  // ---------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------
  if ((BAR_SIZE & (BAR_SIZE - 32'h00000001)) != 32'h00000000) begin : gChk1
    $error("BAR_SIZE must be a power of two");
  end
  if (BAR_SIZE <= {14'h0000, xhci_cap_pkg::EXT_CAP_PTR, 2'b00}) begin
    : gChk2
    $error("BAR_SIZE must cover the extended capability area");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    xhci_cap_pkg::state_t  state;
    logic                  ready;
    logic                  write;
    logic [31:0]           addr;
    logic [3:0]            byteEn;
    logic [7:0]            capLen;
    logic [31:0]           opBase;
    logic                  rspValid;
    logic [31:0]           rspData;
    logic                  rspHit;
    xhci_cap_pkg::region_t region;
    logic [15:0]           relOfs;
    logic                  writeIgnored;
  } core_state_t;

  localparam core_state_t STATE_RESET = '{
    state:        xhci_cap_pkg::ST_IDLE,
    ready:        1'b1,
    write:        1'b0,
    addr:         32'h00000000,
    byteEn:       4'h0,
    capLen:       xhci_cap_pkg::CAPLEN_RESET,
    opBase:       32'h00000000,
    rspValid:     1'b0,
    rspData:      32'h00000000,
    rspHit:       1'b0,
    region:       xhci_cap_pkg::REGION_NONE,
    relOfs:       16'h0000,
    writeIgnored: 1'b0
  };

  core_state_t st_q;
  core_state_t st_d;

  // ---------------------------------------------------------------
  // lanes not enabled read as zero
  // ---------------------------------------------------------------
  function automatic logic [31:0] laneMask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h00000000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  // ---------------------------------------------------------------
  // word table and address decoder
  // ---------------------------------------------------------------
  cap_bank_if bank ();

  assign bank.lookupOfs    = st_q.relOfs;
  assign bank.pwrCtlAbsent = powerCtlAbsent;
  assign bank.capLen       = st_q.capLen;
  assign bank.decAddr      = st_q.addr;
  assign bank.decBase      = barBase;

  cap_word_rom #(
    .HCI_VERSION (HCI_VERSION)
  ) uRom (
    .bank (bank.rom)
  );

  bar_region_decoder #(
    .BAR_SIZE (BAR_SIZE)
  ) uDec (
    .bank (bank.decoder)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_d              = st_q;
    st_d.writeIgnored = 1'b0;
    st_d.rspValid     = 1'b0;
    // capability length is fixed; no write path reaches it
    st_d.capLen       = st_q.capLen;
    st_d.opBase       = barBase + {24'h000000, st_q.capLen};
    unique case (st_q.state)
      xhci_cap_pkg::ST_IDLE: begin
        if (reqValid) begin
          st_d.state  = xhci_cap_pkg::ST_LOOKUP;
          st_d.ready  = 1'b0;
          st_d.write  = reqWrite;
          st_d.addr   = reqAddr;
          st_d.byteEn = reqByteEn;
          // byte offset for the table, valid once region is cap
          st_d.relOfs = 16'(reqAddr - barBase);
        end
      end
      xhci_cap_pkg::ST_LOOKUP: begin
        st_d.state    = xhci_cap_pkg::ST_ANSWER;
        st_d.rspValid = 1'b1;
        st_d.region   = bank.decRegion;
        st_d.relOfs   = bank.decRelOfs;
        st_d.rspHit   = (bank.decRegion == xhci_cap_pkg::REGION_CAP) &&
                        bank.lookupHit;
        st_d.rspData  = 32'h00000000;
        if (st_q.write) begin
          // write is acknowledged and dropped
          st_d.writeIgnored =
            (bank.decRegion == xhci_cap_pkg::REGION_CAP) &&
            bank.lookupHit && (st_q.byteEn != 4'h0);
        end else if ((bank.decRegion == xhci_cap_pkg::REGION_CAP) &&
                     bank.lookupHit) begin
          st_d.rspData = bank.lookupWord & laneMask(st_q.byteEn);
        end
      end
      xhci_cap_pkg::ST_ANSWER: begin
        st_d.state = xhci_cap_pkg::ST_IDLE;
        st_d.ready = 1'b1;
      end
      default: begin
        st_d = STATE_RESET;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= STATE_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reqReady        = st_q.ready;
  assign rspValid        = st_q.rspValid;
  assign rspData         = st_q.rspData;
  assign rspHit          = st_q.rspHit;
  assign rspRegion       = st_q.region;
  assign rspRelOffset    = st_q.relOfs;
  assign operationalBase = st_q.opBase;
  assign writeIgnored    = st_q.writeIgnored;

endmodule

/* File: src/xhci_cap_pkg.sv */
package xhci_cap_pkg;

  // ---------------------------------------------------------------
  // bus widths
  // ---------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int ADDR_W = 32;
  localparam int OFS_W  = 16;
  localparam int BE_W   = 4;

  // ---------------------------------------------------------------
  // capability word offsets from first_base_address
  // ---------------------------------------------------------------
  localparam logic [15:0] OFS_CAPLEN    = 16'h0000;
  localparam logic [15:0] OFS_SPARAMS1  = 16'h0004;
  localparam logic [15:0] OFS_SPARAMS2  = 16'h0008;
  localparam logic [15:0] OFS_SPARAMS3  = 16'h000c;
  localparam logic [15:0] OFS_CAPPARAMS = 16'h0010;
  localparam logic [15:0] OFS_DBOFF     = 16'h0014;
  localparam logic [15:0] OFS_RTSOFF    = 16'h0018;
  localparam logic [15:0] WORD_MASK     = 16'hfffc;

  // ---------------------------------------------------------------
  // reset values and constant fields
  // ---------------------------------------------------------------
  localparam logic [7:0]  CAPLEN_RESET      = 8'h20;
  localparam logic [15:0] HCI_VERSION_RESET = 16'h0096;
  localparam int          VERSION_LSB       = 16;
  localparam logic [15:0] DEEP_EXIT_LAT     = 16'h07ff;
  localparam int          DEEP_EXIT_LSB     = 16;
  localparam logic [7:0]  SHALLOW_EXIT_LAT  = 8'h0a;
  localparam int          SHALLOW_EXIT_LSB  = 0;
  localparam logic [15:0] EXT_CAP_PTR       = 16'h0270;
  localparam int          EXT_CAP_LSB       = 16;
  localparam logic [3:0]  PSA_LIMIT         = 4'hf;
  localparam int          PSA_LSB           = 12;
  localparam int          SBD_BIT           = 9;
  localparam int          FSE_BIT           = 8;
  localparam int          NSS_BIT           = 7;
  localparam int          LTC_BIT           = 6;
  localparam int          LIGHT_RESET_CAPABLE_FLAG_BIT          = 5;
  localparam int          PORT_INDICATOR_FLAG_BIT          = 4;
  localparam int          PPC_BIT           = 3;
  localparam int          CSZ_BIT           = 2;
  localparam int          BNC_BIT           = 1;
  localparam int          WIDE_ADDRESS_FLAG_BIT          = 0;
  localparam logic [31:0] DOORBELL_OFS      = 32'h000005c0;
  localparam logic [31:0] RUNTIME_OFS       = 32'h000004a0;
  localparam logic [31:0] BAR_SIZE_DEFAULT  = 32'h00010000;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    REGION_NONE     = 3'b000,
    REGION_CAP      = 3'b001,
    REGION_OPER     = 3'b010,
    REGION_RUNTIME  = 3'b011,
    REGION_DOORBELL = 3'b100,
    REGION_EXTCAP   = 3'b101
  } region_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_LOOKUP = 2'b01,
    ST_ANSWER = 2'b10
  } state_t;

endpackage

/* File: src/cap_bank_if.sv */
`timescale 1ns/1ps
interface cap_bank_if;
  logic [15:0]              lookupOfs;
  logic [31:0]              lookupWord;
  logic                     lookupHit;
  logic                     pwrCtlAbsent;
  logic [7:0]               capLen;
  logic [31:0]              decAddr;
  logic [31:0]              decBase;
  xhci_cap_pkg::region_t    decRegion;
  logic [15:0]              decRelOfs;

  modport rom (input lookupOfs, pwrCtlAbsent, capLen,
               output lookupWord, lookupHit);
  modport decoder (input decAddr, decBase, capLen,
                   output decRegion, decRelOfs);
  modport core (output lookupOfs, pwrCtlAbsent, capLen, decAddr, decBase,
                input lookupWord, lookupHit, decRegion, decRelOfs);
endinterface

/* File: src/cap_word_rom.sv */
`timescale 1ns/1ps
module cap_word_rom #(
  parameter logic [15:0] HCI_VERSION = xhci_cap_pkg::HCI_VERSION_RESET
) (
  cap_bank_if.rom bank  // word lookup
);
  // ---------------------------------------------------------------
  // capability word contents
  // ---------------------------------------------------------------
  always_comb begin
    bank.lookupWord = 32'h00000000;
    bank.lookupHit  = 1'b1;
    unique case (bank.lookupOfs & xhci_cap_pkg::WORD_MASK)
      xhci_cap_pkg::OFS_CAPLEN: begin
        bank.lookupWord[7:0] = bank.capLen;
        bank.lookupWord[xhci_cap_pkg::VERSION_LSB +: 16] = HCI_VERSION;
      end
      xhci_cap_pkg::OFS_SPARAMS3: begin
        bank.lookupWord[xhci_cap_pkg::DEEP_EXIT_LSB +: 16] =
          xhci_cap_pkg::DEEP_EXIT_LAT;
        bank.lookupWord[xhci_cap_pkg::SHALLOW_EXIT_LSB +: 8] =
          xhci_cap_pkg::SHALLOW_EXIT_LAT;
      end                                         // 15:8 stay zero
      xhci_cap_pkg::OFS_CAPPARAMS: begin
        bank.lookupWord[xhci_cap_pkg::EXT_CAP_LSB +: 16] =
          xhci_cap_pkg::EXT_CAP_PTR;
        bank.lookupWord[xhci_cap_pkg::PSA_LSB +: 4] =
          xhci_cap_pkg::PSA_LIMIT;
        bank.lookupWord[xhci_cap_pkg::SBD_BIT]  = 1'b0;
        bank.lookupWord[xhci_cap_pkg::FSE_BIT]  = 1'b0;
        bank.lookupWord[xhci_cap_pkg::NSS_BIT]  = 1'b0;
        bank.lookupWord[xhci_cap_pkg::LTC_BIT]  = 1'b1;
        bank.lookupWord[xhci_cap_pkg::LIGHT_RESET_CAPABLE_FLAG_BIT] = 1'b1;
        bank.lookupWord[xhci_cap_pkg::PORT_INDICATOR_FLAG_BIT] = 1'b0;
        bank.lookupWord[xhci_cap_pkg::PPC_BIT]  = bank.pwrCtlAbsent;
        bank.lookupWord[xhci_cap_pkg::CSZ_BIT]  = 1'b1;
        bank.lookupWord[xhci_cap_pkg::BNC_BIT]  = 1'b0;
        bank.lookupWord[xhci_cap_pkg::WIDE_ADDRESS_FLAG_BIT] = 1'b1;
      end                                       // 11:10 stay zero
      xhci_cap_pkg::OFS_DBOFF: begin
        bank.lookupWord = xhci_cap_pkg::DOORBELL_OFS;
      end
      xhci_cap_pkg::OFS_RTSOFF: begin
        bank.lookupWord = xhci_cap_pkg::RUNTIME_OFS;
      end
      default: begin
        // structural words 1 and 2 are not served anywhere; they miss and read as zero
        bank.lookupHit = 1'b0;
      end
    endcase
  end
endmodule

/* File: src/bar_region_decoder.sv */
`timescale 1ns/1ps
module bar_region_decoder #(
  parameter logic [31:0] BAR_SIZE = xhci_cap_pkg::BAR_SIZE_DEFAULT
) (
  cap_bank_if.decoder bank  // address routing
);
  // ---------------------------------------------------------------
  // region limits derived from the advertised offsets
  // ---------------------------------------------------------------
  localparam logic [31:0] EXT_CAP_BYTE =
    {14'h0000, xhci_cap_pkg::EXT_CAP_PTR, 2'b00};

  logic [31:0] rel;
  logic [31:0] opStart;

  always_comb begin
    rel           = bank.decAddr - bank.decBase;
    opStart       = {24'h000000, bank.capLen};
    bank.decRegion = xhci_cap_pkg::REGION_NONE;
    bank.decRelOfs = 16'h0000;
    if (rel >= BAR_SIZE) begin
      bank.decRegion = xhci_cap_pkg::REGION_NONE;
    end else if (rel < opStart) begin
      bank.decRegion = xhci_cap_pkg::REGION_CAP;
      bank.decRelOfs = rel[15:0];
    end else if (rel < xhci_cap_pkg::RUNTIME_OFS) begin
      // operational space starts at base plus capability length
      bank.decRegion = xhci_cap_pkg::REGION_OPER;
      bank.decRelOfs = 16'(rel - opStart);
    end else if (rel < xhci_cap_pkg::DOORBELL_OFS) begin
      bank.decRegion = xhci_cap_pkg::REGION_RUNTIME;
      bank.decRelOfs = 16'(rel - xhci_cap_pkg::RUNTIME_OFS);
    end else if (rel < EXT_CAP_BYTE) begin
      bank.decRegion = xhci_cap_pkg::REGION_DOORBELL;
      bank.decRelOfs = 16'(rel - xhci_cap_pkg::DOORBELL_OFS);
    end else begin
      bank.decRegion = xhci_cap_pkg::REGION_EXTCAP;
      bank.decRelOfs = 16'(rel - EXT_CAP_BYTE);
    end
  end
endmodule

/* File: verification/xhci_cap_regs_sva.sv */
`timescale 1ns/1ps
module xhci_cap_regs_sva (
  input wire logic                  clk_sys,         // clock
  input wire logic                  arst_n,          // reset
  input wire logic [31:0]           barBase,         // base
  input wire logic                  powerCtlAbsent,  // config bit
  input wire logic                  reqValid,        // strobe
  input wire logic                  reqWrite,        // write
  input wire logic [31:0]           reqAddr,         // address
  input wire logic [3:0]            reqByteEn,       // lanes
  input wire logic                  reqReady,        // ready
  input wire logic                  rspValid,        // answer
  input wire logic [31:0]           rspData,         // data
  input wire logic                  rspHit,          // hit
  input wire xhci_cap_pkg::region_t rspRegion,       // region
  input wire logic [15:0]           rspRelOffset,    // offset
  input wire logic [31:0]           operationalBase, // oper base
  input wire logic                  writeIgnored     // ro write
);
  // ------------------------------------------------------------
  // request capture
  // ------------------------------------------------------------
  logic        isWr_q;
  logic [3:0]  be_q;
  logic        ppc_q;
  logic [31:0] mask;
  logic        rd;
  assign mask = {{8{be_q[3]}}, {8{be_q[2]}}, {8{be_q[1]}}, {8{be_q[0]}}};
  assign rd = rspValid && !isWr_q && rspHit &&
              rspRegion == xhci_cap_pkg::REGION_CAP;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      isWr_q <= 1'b0;
      be_q   <= 4'h0;
      ppc_q  <= 1'b0;
    end else if (reqValid && reqReady) begin
      isWr_q <= reqWrite;
      be_q   <= reqByteEn;
      ppc_q  <= powerCtlAbsent;
    end
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  property p_answer;
    reqValid && reqReady |=> !rspValid ##1 rspValid;
  endproperty
  a_answer: assert property (p_answer) else $error("answer late");
  property p_ready;
    reqValid && reqReady |=> !reqReady [*2] ##1 reqReady;
  endproperty
  a_ready: assert property (p_ready) else $error("ready wrong");
  property p_word0c;
    rd && rspRelOffset[4:2] == 3'h3 |-> rspData == (32'h07ff000a & mask);
  endproperty
  a_word0c: assert property (p_word0c) else $error("0c bad");
  property p_word10;
    rd && rspRelOffset[4:2] == 3'h4 |->
      rspData == ((32'h0270f065 | {28'h0, ppc_q, 3'h0}) & mask);
  endproperty
  a_word10: assert property (p_word10) else $error("10 bad");
  property p_word14;
    rd && rspRelOffset[4:2] == 3'h5 |-> rspData == (32'h000005c0 & mask);
  endproperty
  a_word14: assert property (p_word14) else $error("14 bad");
  property p_word18;
    rd && rspRelOffset[4:2] == 3'h6 |-> rspData == (32'h000004a0 & mask);
  endproperty
  a_word18: assert property (p_word18) else $error("18 bad");
  property p_word00;
    rd && rspRelOffset[4:2] == 3'h0 |-> rspData[15:0] == (16'h0020 & mask[15:0]);
  endproperty
  a_word00: assert property (p_word00) else $error("00 bad");
  property p_opbase;
    $past(arst_n) |-> operationalBase == $past(barBase) + 32'h00000020;
  endproperty
  a_opbase: assert property (p_opbase) else $error("oper base bad");
  property p_write;
    rspValid && isWr_q |->
      rspData == 32'h0 && writeIgnored == (rspHit && (|be_q));
  endproperty
  a_write: assert property (p_write) else $error("write bad");
  c_ppc: cover property (rd && ppc_q && rspRelOffset[4:2] == 3'h4);
  c_wr: cover property (writeIgnored);
  c_oper: cover property (rspValid && rspRegion == xhci_cap_pkg::REGION_OPER);
endmodule
bind xhci_capability_param_regs xhci_cap_regs_sva xhci_cap_regs_sva_inst (
  .clk_sys(clk_sys), .arst_n(arst_n), .barBase(barBase),
  .powerCtlAbsent(powerCtlAbsent), .reqValid(reqValid), .reqWrite(reqWrite),
  .reqAddr(reqAddr), .reqByteEn(reqByteEn), .reqReady(reqReady),
  .rspValid(rspValid), .rspData(rspData), .rspHit(rspHit),
  .rspRegion(rspRegion), .rspRelOffset(rspRelOffset),
  .operationalBase(operationalBase), .writeIgnored(writeIgnored));

/* File: verification/xhci_capability_param_regs_bench.sv */
`timescale 1ns/1ps
module xhci_capability_param_regs_bench;
  typedef struct packed {
    logic [31:0]           data;
    logic                  hit;
    xhci_cap_pkg::region_t rgn;
    logic [15:0]           rel;
    logic                  wi;
  } exp_t;
  logic clk_sys, arst_n, powerCtlAbsent, reqValid, reqWrite, reqReady;
  logic rspValid, rspHit, writeIgnored;
  logic [31:0] barBase, reqAddr, rspData, operationalBase;
  logic [3:0]  reqByteEn;
  logic [15:0] rspRelOffset;
  xhci_cap_pkg::region_t rspRegion;
  int     n_errors, check_count, cycles;
  integer seed;
  exp_t   q[$];
  exp_t   got;
  logic [31:0] probe [9] = '{32'h20, 32'h49c, 32'h4a0, 32'h5bc, 32'h5c0,
                             32'h9bc, 32'h9c0, 32'hfffc, 32'h10000};
  xhci_capability_param_regs xhci_capability_param_regs_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .barBase(barBase),
    .powerCtlAbsent(powerCtlAbsent), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqAddr(reqAddr), .reqByteEn(reqByteEn),
    .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
    .rspHit(rspHit), .rspRegion(rspRegion), .rspRelOffset(rspRelOffset),
    .operationalBase(operationalBase), .writeIgnored(writeIgnored));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task stop_test();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task check(string name, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h seen %h", name, exp, seen);
    end
  endtask
  function exp_t model(logic wr, logic [31:0] rel, logic [3:0] be);
    exp_t e;
    logic [31:0] w;
    e = '0;
    w = 32'h0;
    e.hit = 1'b1;
    case (rel & 32'hfffffffc)
      32'h00: w = 32'h00960020;
      32'h0c: w = 32'h07ff000a;
      32'h10: w = 32'h0270f065 | {28'h0, powerCtlAbsent, 3'h0};
      32'h14: w = 32'h000005c0;
      32'h18: w = 32'h000004a0;
      default: e.hit = 1'b0;
    endcase
    e.data = wr ? 32'h0 : w & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    e.wi = wr && e.hit && (|be);
    e.rel = rel[15:0];
    if (rel < 32'h20) e.rgn = xhci_cap_pkg::REGION_CAP;
    else if (rel < 32'h4a0) {e.rgn, e.rel} = {xhci_cap_pkg::REGION_OPER, rel[15:0] - 16'h20};
    else if (rel < 32'h5c0) {e.rgn, e.rel} = {xhci_cap_pkg::REGION_RUNTIME, rel[15:0] - 16'h4a0};
    else if (rel < 32'h9c0) {e.rgn, e.rel} = {xhci_cap_pkg::REGION_DOORBELL, rel[15:0] - 16'h5c0};
    else if (rel < 32'h10000) {e.rgn, e.rel} = {xhci_cap_pkg::REGION_EXTCAP, rel[15:0] - 16'h9c0};
    else {e.rgn, e.rel} = {xhci_cap_pkg::REGION_NONE, 16'h0000};
    return e;
  endfunction
  task access(logic wr, logic [31:0] ofs, logic [3:0] be);
    @(posedge clk_sys);
    reqValid  <= 1'b1;
    reqWrite  <= wr;
    reqAddr   <= barBase + ofs;
    reqByteEn <= be;
    q.push_back(model(wr, ofs, be));
    do @(negedge clk_sys); while (reqReady !== 1'b1);
    @(posedge clk_sys);
    reqValid <= 1'b0;
  endtask
  task wait_idle();
    for (int k = 0; k < 20 && q.size() > 0; k++) @(negedge clk_sys);
    @(posedge clk_sys);
  endtask
  // ------------------------------------------------------------
  // response watcher and timeout
  // ------------------------------------------------------------
  always @(negedge clk_sys) begin
    if (arst_n === 1'b1 && rspValid === 1'b1) begin
      if (q.size() == 0) begin
        check("unexpected", 32'h1, 32'h0);
      end else begin
        got = q.pop_front();
        check("rspData", rspData, got.data);
        check("rspHit", 32'(rspHit), 32'(got.hit));
        check("writeIgnored", 32'(writeIgnored), 32'(got.wi));
        check("rspRegion", 32'(rspRegion), 32'(got.rgn));
        check("rspRelOffset", 32'(rspRelOffset), 32'(got.rel));
      end
    end
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      stop_test();
    end
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 32'hac9f;
    arst_n = 1'b0;
    barBase = 32'h40000000;
    powerCtlAbsent = 1'b0;
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqAddr = 32'h0;
    reqByteEn = 4'h0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(negedge clk_sys);
    @(negedge clk_sys);
    check("operationalBase", operationalBase, barBase + 32'h20);
    for (int i = 0; i < 8; i++) access(1'b0, 32'(i * 4), 4'hf);
    powerCtlAbsent <= 1'b1;
    access(1'b0, 32'h13, 4'hf);
    access(1'b0, 32'h10, 4'h3);
    for (int i = 3; i < 7; i++) access(1'b1, 32'(i * 4), 4'hf);
    access(1'b1, 32'h10, 4'h0);
    access(1'b0, 32'h14, 4'hf);
    foreach (probe[i]) access(1'b0, probe[i], 4'hf);
    for (int i = 0; i < 40; i++) begin
      if (i % 8 == 0) begin
        wait_idle();
        barBase <= $random(seed) & 32'hfff00000;
        powerCtlAbsent <= 1'($random(seed));
        repeat (2) @(negedge clk_sys);
        check("operationalBase", operationalBase, barBase + 32'h20);
      end
      access(1'($random(seed)), $random(seed) & 32'h00000fff, 4'($random(seed)));
    end
    wait_idle();
    arst_n <= 1'b0;
    @(negedge clk_sys);
    check("reqReady", 32'(reqReady), 32'h1);
    check("operationalBase", operationalBase, 32'h0);
    check("rspValid", 32'(rspValid), 32'h0);
    check("writeIgnored", 32'(writeIgnored), 32'h0);
    @(posedge clk_sys);
    arst_n <= 1'b1;
    access(1'b0, 32'h0, 4'hf);
    wait_idle();
    check("pending", 32'(q.size()), 32'h0);
    stop_test();
  end
endmodule
